// file: verilog/phs_status_regs.sv
// Transceiver status register bank behind an APB slave; read-only except the interrupt status and mask registers.
// Assumes live status and strap inputs are synchronous to clk, and that
// rst_n is the transceiver reset that also re-takes the recommendations.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps

module phs_status_regs
  import phs_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Transceiver core status
  input  wire phs_live_t         live_i,
  input  wire phs_strap_t        strap_i,
  // Interrupt
  output logic                   irq
);

  // Sampled live status and its previous value for change detection
  phs_live_t        live_q;
  phs_live_t        live_prev_q;
  // Recommendation latches
  logic             rec_taken_q;      // Set once values are taken
  logic             fiber_mode_active_q;
  logic             pause_rec_q;
  logic             duplex_rec_q;
  logic             speed_rec_q;
  logic             autoneg_rec_q;
  // Interrupt state
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clr;
  logic             irq_q;
  // Bus state
  logic [31:0]      prdata_q;
  logic             pslverr_q;
  logic [9:0]       acc_idx;          // Word index of the access
  logic             acc_aligned;      // Low address bits are zero
  logic             bus_setup;        // First cycle of a transfer
  logic             bus_write;        // Write taking effect this edge
  logic [31:0]      rd_word;          // Read mux result
  logic             rd_hit;           // Address maps to a register
  logic [15:0]      gen_word;
  logic [15:0]      spec_word;

  // Live fields are taken every clock so software sees them in real time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      live_q      <= LIVE_RST;
      live_prev_q <= LIVE_RST;
    end else begin
      live_q      <= live_i;
      live_prev_q <= live_q;
    end
  end

  // Recommendations are caught on the first clock after reset release.
  // Catching them there, rather than during reset, keeps the reset path a
  // pure constant load; the fields read zero until then.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rec_taken_q         <= 1'b0;
      fiber_mode_active_q <= 1'b0;
      pause_rec_q         <= 1'b0;
      duplex_rec_q        <= 1'b0;
      speed_rec_q         <= 1'b0;
      autoneg_rec_q       <= 1'b0;
    end else if (!rec_taken_q) begin
      rec_taken_q         <= 1'b1;
      // Fiber when either the strap or the config bit asks for it
      fiber_mode_active_q <= strap_i.fiber_select_strap |
                             strap_i.fiber_select_cfg;
      // Pause recommendation is void without full duplex
      pause_rec_q         <= strap_i.pause_recommend &
                             strap_i.duplex_recommend;
      duplex_rec_q        <= strap_i.duplex_recommend;
      speed_rec_q         <= strap_i.speed_recommend;
      autoneg_rec_q       <= strap_i.autoneg_recommend;
    end
    // Otherwise every latch holds until the next reset
  end

  // Generic status word
  always_comb begin
    gen_word            = GENERIC_RST;
    gen_word[GS_MEDIUM] = live_q.medium_detect_state;
    gen_word[GS_FIBER]  = fiber_mode_active_q;
    gen_word[GS_CROSSOVER_STATE]  = live_q.crossover_state;
    // Length estimate only means something at 100M; reads zero at 10M
    if (live_q.operating_speed) begin
      gen_word[GS_CBL_MSB:GS_CBL_LSB] = live_q.cable_length_code;
    end else begin
      gen_word[GS_CBL_MSB:GS_CBL_LSB] = CABLE_NONE;
    end
  end

  // Specific status word
  always_comb begin
    spec_word           = '0;
    spec_word[SS_RXJAB] = live_q.rx_jabber_live;
    spec_word[SS_TXJAB] = live_q.tx_jabber_live;
    // Polarity is only judged at 10M; at 100M it reads normal
    spec_word[SS_POL]   = live_q.rx_polarity_reversed &
                          ~live_q.operating_speed;
    // Half duplex forces pause out to absent
    spec_word[SS_PAUSE_OUT_ABILITY]  = live_q.pause_out_ability &
                          live_q.operating_duplex;
    // Pause in is inverted: half duplex forces the absent code, 1
    spec_word[SS_PIN]   = live_q.pause_in_lacking |
                          ~live_q.operating_duplex;
    spec_word[SS_DUP]   = live_q.operating_duplex;
    spec_word[SS_SPD]   = live_q.operating_speed;
    spec_word[SS_LINK]  = live_q.link_up;
    spec_word[SS_PAUSE_RECOMMEND]  = pause_rec_q & duplex_rec_q;
    spec_word[SS_DUPLEX_RECOMMEND]  = duplex_rec_q;
    spec_word[SS_SPEED_RECOMMEND]  = speed_rec_q;
    spec_word[SS_AUTONEG_RECOMMEND]  = autoneg_rec_q;
  end

  // Change events from the sampled live status
  always_comb begin
    irq_event             = '0;
    irq_event[IRQ_LINK]   = live_q.link_up ^ live_prev_q.link_up;
    // Jabber counts on entry only, not while it lasts
    irq_event[IRQ_RXJAB]  = live_q.rx_jabber_live &
                            ~live_prev_q.rx_jabber_live;
    irq_event[IRQ_TXJAB]  = live_q.tx_jabber_live &
                            ~live_prev_q.tx_jabber_live;
    irq_event[IRQ_CROSSOVER_STATE]  = live_q.crossover_state ^
                            live_prev_q.crossover_state;
    irq_event[IRQ_MEDIUM] = live_q.medium_detect_state ^
                            live_prev_q.medium_detect_state;
    irq_event[IRQ_SPEED]  = live_q.operating_speed ^
                            live_prev_q.operating_speed;
  end

  // Bus phase decode
  assign acc_idx     = paddr[11:2];
  assign acc_aligned = (paddr[1:0] == 2'h0);
  assign bus_setup   = psel & ~penable;
  assign bus_write   = psel & penable & pwrite & pready & ~pslverr_q;

  // Read mux; also tells whether the address is mapped
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b0;
    if (!acc_aligned) begin
      rd_hit  = 1'b0;
    end else if (acc_idx == IDX_GENERIC) begin
      rd_word = {16'h0000, gen_word};
      rd_hit  = 1'b1;
    end else if (acc_idx == IDX_SPECIFIC) begin
      rd_word = {16'h0000, spec_word};
      rd_hit  = 1'b1;
    end else if (acc_idx > IDX_SPECIFIC && acc_idx <= IDX_GROUP_HI) begin
      // Rest of the status group holds nothing here and reads zero
      rd_hit  = 1'b1;
    end else if (acc_idx >= IDX_RSV_LO && acc_idx <= IDX_RSV_HI) begin
      // Kept free for later status; reads zero, no error
      rd_hit  = 1'b1;
    end else if (acc_idx == IDX_IRQ_STAT) begin
      rd_word = {26'h000_0000, irq_stat_q};
      rd_hit  = 1'b1;
    end else if (acc_idx == IDX_IRQ_MASK) begin
      rd_word = {26'h000_0000, irq_mask_q};
      rd_hit  = 1'b1;
    end
  end

  // Read data and error are taken in the setup cycle and shown in access.
  // Trade-off: reads see the state one cycle before the access edge, which
  // keeps prdata a flop output with zero wait states.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (bus_setup) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr_q <= ~rd_hit;
    end
  end

  // Write-one-to-clear strobe; only the low byte lane carries the bits
  assign irq_clr = (bus_write && acc_idx == IDX_IRQ_STAT && acc_aligned &&
                    pstrb[0]) ? pwdata[IRQ_W-1:0] : '0;

  // Sticky interrupt bits; an event in the clearing cycle wins
  generate
    for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          irq_stat_q[i] <= 1'b0;
        end else if (irq_event[i]) begin
          irq_stat_q[i] <= 1'b1;
        end else if (irq_clr[i]) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Mask register; status register writes never touch status fields
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_mask_q <= IRQ_MASK_RST;
    end else if (bus_write && acc_idx == IDX_IRQ_MASK && acc_aligned &&
                 pstrb[0]) begin
      irq_mask_q <= pwdata[IRQ_W-1:0];
    end
    // Writes to the status group fall through here unused
  end

  // Interrupt level, one cycle behind the sticky bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Outputs
  assign prdata  = prdata_q;
  assign pready  = 1'b1;      // Zero wait states
  assign pslverr = psel & penable & pslverr_q;
  assign irq     = irq_q;

endmodule

// file: verilog/phs_pkg.sv
// Constants, field layouts and carrier types for the status register bank.
// Assumes an APB slave with 32-bit data; registers sit at word index * 4.
package phs_pkg;

  // APB address width in bits
  localparam int unsigned APB_AW = 12;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_GROUP_LO  = 10'h016;
  localparam logic [9:0] IDX_GENERIC   = 10'h016;
  localparam logic [9:0] IDX_SPECIFIC  = 10'h017;
  localparam logic [9:0] IDX_GROUP_HI  = 10'h01C;
  localparam logic [9:0] IDX_RSV_LO    = 10'h01D;
  localparam logic [9:0] IDX_RSV_HI    = 10'h01E;
  localparam logic [9:0] IDX_IRQ_STAT  = 10'h020;
  localparam logic [9:0] IDX_IRQ_MASK  = 10'h021;

  // Generic status field positions
  localparam int unsigned GS_MEDIUM   = 10;
  localparam int unsigned GS_FIBER    = 9;
  localparam int unsigned GS_CROSSOVER_STATE    = 8;
  localparam int unsigned GS_CBL_MSB  = 7;
  localparam int unsigned GS_CBL_LSB  = 0;

  // Specific status field positions
  localparam int unsigned SS_RXJAB    = 11;
  localparam int unsigned SS_TXJAB    = 10;
  localparam int unsigned SS_POL      = 9;
  localparam int unsigned SS_PAUSE_OUT_ABILITY     = 8;
  localparam int unsigned SS_PIN      = 7;
  localparam int unsigned SS_DUP      = 6;
  localparam int unsigned SS_SPD      = 5;
  localparam int unsigned SS_LINK     = 4;
  localparam int unsigned SS_PAUSE_RECOMMEND     = 3;
  localparam int unsigned SS_DUPLEX_RECOMMEND     = 2;
  localparam int unsigned SS_SPEED_RECOMMEND     = 1;
  localparam int unsigned SS_AUTONEG_RECOMMEND     = 0;

  // Reset values
  localparam logic [15:0] GENERIC_RST  = 16'h0000;
  localparam logic [15:0] SPECIFIC_RST = 16'h0060;
  localparam logic [7:0]  CABLE_NONE   = 8'h00;

  // Cable length codes reported at 100M
  localparam logic [7:0]  CBL_40M      = 8'h1A;
  localparam logic [7:0]  CBL_60M      = 8'h22;
  localparam logic [7:0]  CBL_80M      = 8'h94;
  localparam logic [7:0]  CBL_100M     = 8'h9A;
  localparam logic [7:0]  CBL_120M     = 8'hA2;
  localparam logic [7:0]  CBL_140M     = 8'hAB;

  // Interrupt status / mask layout
  localparam int unsigned IRQ_LINK    = 0;
  localparam int unsigned IRQ_RXJAB   = 1;
  localparam int unsigned IRQ_TXJAB   = 2;
  localparam int unsigned IRQ_CROSSOVER_STATE   = 3;
  localparam int unsigned IRQ_MEDIUM  = 4;
  localparam int unsigned IRQ_SPEED   = 5;
  localparam int unsigned IRQ_W       = 6;
  localparam logic [5:0]  IRQ_MASK_RST = 6'h00;

  // Live status from the transceiver core
  typedef struct packed {
    logic       medium_detect_state;
    logic       crossover_state;
    logic [7:0] cable_length_code;
    logic       rx_jabber_live;
    logic       tx_jabber_live;
    logic       rx_polarity_reversed;
    logic       pause_out_ability;
    logic       pause_in_lacking;
    logic       operating_duplex;
    logic       operating_speed;
    logic       link_up;
  } phs_live_t;

  // Values taken only once after transceiver reset
  typedef struct packed {
    logic fiber_select_strap;
    logic fiber_select_cfg;
    logic pause_recommend;
    logic duplex_recommend;
    logic speed_recommend;
    logic autoneg_recommend;
  } phs_strap_t;

  // Live word after reset: full duplex, 100M, everything else clear
  localparam phs_live_t LIVE_RST = '{
    medium_detect_state:  1'b0,
    crossover_state:      1'b0,
    cable_length_code:    8'h00,
    rx_jabber_live:       1'b0,
    tx_jabber_live:       1'b0,
    rx_polarity_reversed: 1'b0,
    pause_out_ability:    1'b0,
    pause_in_lacking:     1'b0,
    operating_duplex:     1'b1,
    operating_speed:      1'b1,
    link_up:              1'b0
  };

endpackage

// file: bench/phs_status_checker.sv
// Port checker for the status register bank.
// Assumes zero-wait APB and live inputs synchronous to clk.
`timescale 1ns/1ps
module phs_status_checker
  import phs_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Core status and interrupt
  input wire phs_live_t         live_i,
  input wire logic              irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  phs_live_t  prev_q;  // Live word one sample back
  logic [1:0] stab_q;  // Steady cycles; reads judged once settled
  logic       rd_a;    // Read access phase

  assign rd_a = psel && penable && !pwrite;

  // Count steady cycles, since read data lags the input by two edges
  always_ff @(posedge clk) begin
    prev_q <= live_i;
    if (!rst_n || live_i != prev_q) begin
      stab_q <= 2'h0;
    end else if (stab_q != 2'h3) begin
      stab_q <= stab_q + 2'h1;
    end
  end

  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  chk_misalign_err:
    assert property (rd_a && paddr[1:0] != 2'h0 |-> pslverr && prdata == 0)
    else $error("misaligned read not refused");
  chk_rsv_idx_zero:
    assert property (rd_a && paddr >= 12'h060 && paddr <= 12'h078 &&
      paddr[1:0] == 2'h0
      |-> prdata == 32'h0 && !pslverr) else $error("reserved index not 0");
  chk_gen_rsv_zero:
    assert property (rd_a && paddr == 12'h058 |-> prdata[31:11] == 0)
    else $error("generic reserved bits set");
  chk_spec_rsv_zero:
    assert property (rd_a && paddr == 12'h05C |-> prdata[31:12] == 0)
    else $error("specific reserved bits set");
  chk_spec_live:
    assert property (rd_a && paddr == 12'h05C && stab_q[1] |->
      prdata[11:4] == {prev_q.rx_jabber_live, prev_q.tx_jabber_live,
      prev_q.rx_polarity_reversed & ~prev_q.operating_speed,
      prev_q.pause_out_ability & prev_q.operating_duplex,
      prev_q.pause_in_lacking | ~prev_q.operating_duplex,
      prev_q.operating_duplex, prev_q.operating_speed, prev_q.link_up})
    else $error("specific live fields wrong");
  chk_gen_live:
    assert property (rd_a && paddr == 12'h058 && stab_q[1] |->
      prdata[10] == prev_q.medium_detect_state &&
      prdata[8] == prev_q.crossover_state && prdata[7:0] ==
      (prev_q.operating_speed ? prev_q.cable_length_code : 8'h00))
    else $error("generic live fields wrong");
  chk_pause_rec:
    assert property (rd_a && paddr == 12'h05C |-> !(prdata[3] && !prdata[2]))
    else $error("pause recommend set at half duplex");
  chk_irq_reset: assert property ($rose(rst_n) |-> !irq)
    else $error("irq high after reset");

  // Main scenarios
  cov_live_read: cover property (rd_a && paddr == 12'h05C && stab_q[1]);
  cov_refused: cover property (pslverr);
  cov_irq_rise: cover property ($rose(irq));
endmodule

bind phs_status_regs phs_status_checker chk_u (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .live_i(live_i), .irq(irq)
);

// file: bench/test_phy_status_registers.sv
// Self-checking bench for the status register bank.
// Drives APB and core status itself; one 50 MHz clock, sync reset.
`timescale 1ns/1ps
`define CK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_phy_status_registers
  import phs_pkg::*;
;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] es_v, eg_v;  // Expected status words
  phs_live_t   live_i, v;
  phs_strap_t  strap_i;
  int          checks, fails;
  // Strap sets with expected reads after each reset
  phs_strap_t  st [3] = '{6'h00, 6'h1D, 6'h2B};
  logic [15:0] es [3] = '{16'h0060, 16'h006D, 16'h0063};
  logic [15:0] eg [3] = '{16'h0000, 16'h0200, 16'h0200};
  logic [7:0]  cb [8] = '{CBL_40M, CBL_60M, CBL_80M, CBL_100M,
                          CBL_120M, CBL_140M, 8'h5A, 8'hC3};

  phs_status_regs dut_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .live_i(live_i), .strap_i(strap_i), .irq(irq)
  );

  always #10 clk = ~clk;

  // One APB transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read and compare, expecting no error
  task automatic rd_ck(input string n, input logic [11:0] a,
                       input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CK(n, e, rd)
    `CK("pslverr", 1'b0, er)
  endtask

  // Straps are taken on the first edge after release
  task automatic do_reset(input phs_strap_t s);
    @(posedge clk);
    strap_i <= s;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    {clk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    live_i = LIVE_RST;
    strap_i = '0;
    for (int i = 0; i < 3; i++) begin
      do_reset(st[i]);
      rd_ck("spec", 12'h05C, {16'h0, es[i]});
      rd_ck("gen", 12'h058, {16'h0, eg[i]});
      strap_i <= ~st[i];
      repeat (3) @(posedge clk);
      rd_ck("spec hold", 12'h05C, {16'h0, es[i]});
      rd_ck("gen hold", 12'h058, {16'h0, eg[i]});
    end
    // Writes to read-only words must leave them unchanged
    xfer(1'b1, 12'h05C, 32'hFFFFFFFF);
    xfer(1'b1, 12'h058, 32'hFFFFFFFF);
    rd_ck("spec wr", 12'h05C, {16'h0, es[2]});
    rd_ck("gen wr", 12'h058, {16'h0, eg[2]});
    for (int a = 12'h060; a <= 12'h078; a += 4) begin
      rd_ck("rsv", a[11:0], 32'h0);
    end
    foreach (cb[i]) begin
      v = LIVE_RST;
      v.cable_length_code = cb[i];
      v.operating_speed = (i < 6);
      v.operating_duplex = i[0];
      {v.rx_jabber_live, v.pause_in_lacking, v.crossover_state} = {3{i[1]}};
      {v.tx_jabber_live, v.link_up} = {2{i[2]}};
      v.medium_detect_state = i[0];
      {v.rx_polarity_reversed, v.pause_out_ability} = 2'h3;
      // Recommendation bits stay as latched at the last reset
      es_v = es[2];
      es_v[9:4] = {v.rx_polarity_reversed & ~v.operating_speed,
                   v.pause_out_ability & v.operating_duplex,
                   v.pause_in_lacking | ~v.operating_duplex,
                   v.operating_duplex, v.operating_speed, v.link_up};
      es_v[11:10] = {v.rx_jabber_live, v.tx_jabber_live};
      eg_v = {5'h0, v.medium_detect_state, 1'b1, v.crossover_state,
              v.operating_speed ? cb[i] : 8'h00};
      live_i <= v;
      repeat (2) @(posedge clk);
      rd_ck("spec live", 12'h05C, {16'h0, es_v});
      rd_ck("gen live", 12'h058, {16'h0, eg_v});
    end
    foreach (cb[i]) begin
      xfer(1'b0, i[0] ? 12'h05A : 12'h100, 32'h0);
      `CK("refused", 1'b1, er)
      `CK("refused data", 32'h0, rd)
      if (i == 1) break;
    end
    // Interrupt: raise masked, unmask, then clear
    xfer(1'b1, 12'h084, 32'h0);
    xfer(1'b1, 12'h080, 32'h3F);
    v.link_up = ~v.link_up;
    live_i <= v;
    repeat (5) @(posedge clk);
    `CK("irq masked", 1'b0, irq)
    rd_ck("irq stat", 12'h080, 32'h1);
    xfer(1'b1, 12'h084, 32'h1);
    rd_ck("irq mask", 12'h084, 32'h1);
    `CK("irq on", 1'b1, irq)
    xfer(1'b1, 12'h080, 32'h1);
    repeat (3) @(posedge clk);
    `CK("irq off", 1'b0, irq)
    rd_ck("irq clr", 12'h080, 32'h0);
    close_out();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule
